// ===== ioxp_expander.sv
// eight-bit port expander behind a two-wire serial slave
// assumes scl, sda, address straps and port pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "ioxp_params.svh"

module ioxp_expander
(
    input wire logic clk, // 40 MHz core clock
    input wire logic rst, // synchronous reset, active high
    input wire logic scl, // serial clock level
    input wire logic sdaIn, // serial data level on the wire
    output logic sdaOut, // serial data drive value, always low
    output logic sdaOe, // high while pulling serial data low
    input wire logic [2:0] addrSel, // address strap pins
    input wire logic [7:0] portIn, // port pin levels
    output ioxp_pkg::ioxp_port_s portDrv, // port drive values and enables
    output logic intOut, // interrupt drive value, always low
    output logic intOe // high while pulling interrupt low
);
    import ioxp_pkg::*;

    ioxp_regs_s q;
    ioxp_regs_s d;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic adrEv;
    logic adrHit;
    logic wrEv;
    logic ldEv;
    logic [7:0] rdData;

    always_comb
    begin
        d = q;
        adrEv = 1'b0;
        adrHit = 1'b0;
        wrEv = 1'b0;
        ldEv = 1'b0;
        rdData = 8'h00;
        d.lowLevel = 1'b0;
        // two-stage synchronisers, third stage only for edge finding
        d.sclS1 = scl;
        d.sclS2 = q.sclS1;
        d.sclPrev = q.sclS2;
        d.sdaS1 = sdaIn;
        d.sdaS2 = q.sdaS1;
        d.sdaPrev = q.sdaS2;
        d.pinS1 = portIn;
        d.pinS2 = q.pinS1;
        d.selS1 = addrSel;
        d.selS2 = q.selS1;
        sclRise = q.sclS2 & ~q.sclPrev;
        sclFall = ~q.sclS2 & q.sclPrev;
        startCond = q.sclS2 & q.sclPrev & q.sdaPrev & ~q.sdaS2;
        stopCond = q.sclS2 & q.sclPrev & ~q.sdaPrev & q.sdaS2;
        // settle the pin snapshot while synchronisers fill after reset
        if (q.initCnt != `IOXP_INIT_CYCLES)
        begin
            d.initCnt = q.initCnt + 2'h1;
            d.inReg = q.pinS2;
        end
        if (startCond)
        begin
            d.st = IOXP_ADDR;
            d.bitCnt = 4'h0;
            d.sdaOe = 1'b0;
        end
        else if (stopCond)
        begin
            d.st = IOXP_IDLE;
            d.sdaOe = 1'b0;
        end
        else if (sclRise)
        begin
            unique case (q.st)
                IOXP_ADDR, IOXP_CMD, IOXP_WDATA:
                begin
                    d.shift = {q.shift[6:0], q.sdaS2};
                    d.bitCnt = q.bitCnt + 4'h1;
                end
                IOXP_RDATA:
                begin
                    d.bitCnt = q.bitCnt + 4'h1;
                end
                IOXP_MACK:
                begin
                    d.mNack = q.sdaS2;
                end
                default:
                begin
                end
            endcase
        end
        else if (sclFall)
        begin
            unique case (q.st)
                IOXP_ADDR:
                begin
                    if (q.bitCnt == `IOXP_BYTE_BITS)
                    begin
                        adrEv = 1'b1;
                        adrHit = (q.shift[7:4] == `IOXP_FIXED_ADDR) && (q.shift[3:1] == q.selS2);
                        if (adrHit)
                        begin
                            d.st = IOXP_ACK;
                            d.sdaOe = 1'b1;
                            d.ackNext = q.shift[0] ? IOXP_RDATA : IOXP_CMD;
                        end
                        else
                        begin
                            d.st = IOXP_IDLE;
                        end
                    end
                end
                IOXP_CMD:
                begin
                    if (q.bitCnt == `IOXP_BYTE_BITS)
                    begin
                        d.cmd = q.shift[1:0];
                        d.st = IOXP_ACK;
                        d.sdaOe = 1'b1;
                        d.ackNext = IOXP_WDATA;
                    end
                end
                IOXP_WDATA:
                begin
                    if (q.bitCnt == `IOXP_BYTE_BITS)
                    begin
                        wrEv = 1'b1;
                        d.st = IOXP_ACK;
                        d.sdaOe = 1'b1;
                        d.ackNext = IOXP_WDATA;
                        unique case (q.cmd)
                            `IOXP_CMD_INPUT:
                            begin
                            end
                            `IOXP_CMD_OUTPUT: d.outReg = q.shift;
                            `IOXP_CMD_POLARITY: d.polReg = q.shift;
                            `IOXP_CMD_CONFIG: d.cfgReg = q.shift;
                        endcase
                    end
                end
                IOXP_ACK:
                begin
                    d.bitCnt = 4'h0;
                    d.sdaOe = 1'b0;
                    d.st = q.ackNext;
                    ldEv = (q.ackNext == IOXP_RDATA);
                end
                IOXP_RDATA:
                begin
                    if (q.bitCnt == `IOXP_BYTE_BITS)
                    begin
                        d.sdaOe = 1'b0;
                        d.st = IOXP_MACK;
                    end
                    else
                    begin
                        d.shift = {q.shift[6:0], 1'b0};
                        d.sdaOe = ~q.shift[6];
                    end
                end
                IOXP_MACK:
                begin
                    if (q.mNack)
                    begin
                        d.st = IOXP_IDLE;
                    end
                    else
                    begin
                        ldEv = 1'b1;
                        d.bitCnt = 4'h0;
                        d.st = IOXP_RDATA;
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (ldEv)
        begin
            unique case (q.cmd)
                `IOXP_CMD_INPUT: rdData = q.pinS2 ^ q.polReg;
                `IOXP_CMD_OUTPUT: rdData = q.outReg;
                `IOXP_CMD_POLARITY: rdData = q.polReg;
                `IOXP_CMD_CONFIG: rdData = q.cfgReg;
            endcase
            d.shift = rdData;
            d.sdaOe = ~rdData[7];
            if (q.cmd == `IOXP_CMD_INPUT)
            begin
                d.inReg = q.pinS2;
            end
        end
        d.port.oe = ~d.cfgReg;
        d.port.val = d.outReg;
        d.intOe = (q.initCnt == `IOXP_INIT_CYCLES) && (q.pinS2 != d.inReg);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.outReg <= `IOXP_OUT_RST;
            q.polReg <= `IOXP_POL_RST;
            q.cfgReg <= `IOXP_CFG_RST;
            q.port.val <= `IOXP_OUT_RST;
            // idle bus level, so no false edge right after reset
            q.sclS1 <= 1'b1;
            q.sclS2 <= 1'b1;
            q.sclPrev <= 1'b1;
            q.sdaS1 <= 1'b1;
            q.sdaS2 <= 1'b1;
            q.sdaPrev <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign sdaOut = q.lowLevel;
    assign sdaOe = q.sdaOe;
    assign portDrv = q.port;
    assign intOut = q.lowLevel;
    assign intOe = q.intOe;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence sByteEnd;
        sclFall && (q.bitCnt == `IOXP_BYTE_BITS);
    endsequence

    sequence sAddrMatch;
        sByteEnd and (q.st == IOXP_ADDR) and adrHit;
    endsequence

    sequence sReadLoad;
        ldEv && (q.cmd == `IOXP_CMD_INPUT);
    endsequence

    a_reset_defaults: assert property ($fell(rst) |-> (q.port.oe == 8'h00) && (q.outReg == `IOXP_OUT_RST)
        && (q.st == IOXP_IDLE) && !q.sdaOe)
    else $error("defaults missing after reset");

    a_dir_applied: assert property (q.port.oe == ~q.cfgReg)
    else $error("pin enable disagrees with direction bit");

    a_out_drive: assert property (q.port.val == q.outReg)
    else $error("pin drive disagrees with output bit");

    a_out_latched: assert property (!(wrEv && (q.cmd == `IOXP_CMD_OUTPUT)) |=> $stable(q.outReg))
    else $error("output register changed without write");

    a_out_write: assert property (wrEv && (q.cmd == `IOXP_CMD_OUTPUT) |=> q.outReg == $past(q.shift))
    else $error("output write not stored");

    a_cmd_held: assert property (!(sclFall && (q.bitCnt == `IOXP_BYTE_BITS) && (q.st == IOXP_CMD))
        |=> $stable(q.cmd))
    else $error("command pointer changed without command byte");

    a_addr_ack: assert property (sAddrMatch |=> q.sdaOe && (q.st == IOXP_ACK) ##1 q.sdaOe [*1])
    else $error("matching address not acknowledged");

    a_addr_ignore: assert property (adrEv && !adrHit |=> !q.sdaOe && (q.st == IOXP_IDLE))
    else $error("foreign address acknowledged");

    a_read_input: assert property (ldEv && (q.cmd == `IOXP_CMD_INPUT)
        |=> (q.shift == (q.inReg ^ q.polReg)) && (q.sdaOe == ~q.shift[7]))
    else $error("input read value wrong");

    a_read_output: assert property (ldEv && (q.cmd == `IOXP_CMD_OUTPUT) |=> q.shift == $past(q.outReg))
    else $error("output read value wrong");

    a_int_follow: assert property (sReadLoad |=> !q.intOe)
    else $error("interrupt not released by input read");

    a_int_cause: assert property ((q.initCnt == `IOXP_INIT_CYCLES) && (q.pinS2 != q.inReg) && !ldEv
        |=> q.intOe)
    else $error("interrupt not raised on changed pin");

    a_int_clear: assert property ((q.pinS2 == q.inReg) && !ldEv && $stable(q.pinS2) |=> !q.intOe)
    else $error("interrupt not released");

    a_cfg_write: assert property (wrEv && (q.cmd == `IOXP_CMD_CONFIG) |=> ##1 q.port.oe == ~$past(q.shift, 2))
    else $error("direction write not applied to pins");

endmodule

`default_nettype wire

// ===== ioxp_params.svh
// constants for the eight-bit serial port expander
// assumes a 40 MHz core clock oversampling the serial clock and data lines
`ifndef IOXP_PARAMS_SVH
`define IOXP_PARAMS_SVH

`define IOXP_FIXED_ADDR 4'h4
`define IOXP_CMD_INPUT 2'h0
`define IOXP_CMD_OUTPUT 2'h1
`define IOXP_CMD_POLARITY 2'h2
`define IOXP_CMD_CONFIG 2'h3
`define IOXP_OUT_RST 8'hff
`define IOXP_POL_RST 8'h00
`define IOXP_CFG_RST 8'hff
`define IOXP_BYTE_BITS 4'h8
`define IOXP_INIT_CYCLES 2'h3

`endif

// ===== ioxp_pkg.sv
// types shared by the port expander design
// assumes ioxp_params.svh is on the include path
`default_nettype none

package ioxp_pkg;

    typedef enum logic [2:0] {
        IOXP_IDLE = 3'h0,
        IOXP_ADDR = 3'h1,
        IOXP_CMD = 3'h2,
        IOXP_WDATA = 3'h3,
        IOXP_RDATA = 3'h4,
        IOXP_ACK = 3'h5,
        IOXP_MACK = 3'h6
    } ioxp_state_e;

    typedef struct packed {
        logic [7:0] val;
        logic [7:0] oe;
    } ioxp_port_s;

    typedef struct packed {
        ioxp_state_e st;
        ioxp_state_e ackNext;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic mNack;
        logic sclS1;
        logic sclS2;
        logic sclPrev;
        logic sdaS1;
        logic sdaS2;
        logic sdaPrev;
        logic [7:0] pinS1;
        logic [7:0] pinS2;
        logic [2:0] selS1;
        logic [2:0] selS2;
        logic [1:0] initCnt;
        logic [1:0] cmd;
        logic [7:0] inReg;
        logic [7:0] outReg;
        logic [7:0] polReg;
        logic [7:0] cfgReg;
        logic sdaOe;
        logic intOe;
        logic lowLevel;
        ioxp_port_s port;
    } ioxp_regs_s;

endpackage

`default_nettype wire

// ===== ioxp_host_model.sv
// two-wire bus master model driving the port expander
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none

module ioxp_host_model
(
    input wire logic clk, // bench clock
    input wire logic sdaLine, // resolved data wire level
    output logic scl, // serial clock, idles high
    output logic sdaLow // high while pulling data low
);
    initial
    begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // data moves in the low phase, sampled at the end of the high phase
    task automatic bitXfer(input logic b, output logic r);
        scl <= 1'b0;
        tick(1);
        sdaLow <= ~b;
        tick(3);
        scl <= 1'b1;
        tick(4);
        r = sdaLine;
    endtask

    // also serves as repeated start
    task automatic start();
        scl <= 1'b0;
        tick(1);
        sdaLow <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sdaLow <= 1'b1;
        tick(4);
    endtask

    task automatic stop();
        scl <= 1'b0;
        tick(1);
        sdaLow <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sdaLow <= 1'b0;
        tick(4);
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitXfer(b[i], r);
        bitXfer(1'b1, ack);
    endtask

    // one byte, then no-acknowledge if last, else acknowledge
    task automatic recvByte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitXfer(1'b1, r);
            d[i] = r;
        end
        bitXfer(last, r);
    endtask

    task automatic xfer(input logic [2:0] a, input logic rd, output logic ack);
        start();
        sendByte({4'h4, a, rd}, ack);
    endtask

    task automatic regWrite(input logic [2:0] a, input logic [1:0] cmd, input logic [7:0] d, output logic ack);
        logic k0;
        logic k1;
        logic k2;
        xfer(a, 1'b0, k0);
        sendByte({6'h00, cmd}, k1);
        sendByte(d, k2);
        stop();
        ack = k0 | k1 | k2;
    endtask

    task automatic regRead(input logic [2:0] a, input logic setCmd, input logic [1:0] cmd, output logic [7:0] d);
        logic k;
        if (setCmd)
        begin
            xfer(a, 1'b0, k);
            sendByte({6'h00, cmd}, k);
        end
        xfer(a, 1'b1, k);
        recvByte(1'b1, d);
        stop();
    endtask

    // two bytes in one read, first one acknowledged
    task automatic regRead2(input logic [2:0] a, output logic [7:0] d0, output logic [7:0] d1);
        logic k;
        xfer(a, 1'b1, k);
        recvByte(1'b0, d0);
        recvByte(1'b1, d1);
        stop();
    endtask
endmodule

`default_nettype wire

// ===== tb.sv
// self-checking bench for the eight-bit port expander
// assumes ioxp_host_model on the bus; pins resolve by drive enable
`timescale 1ns/1ps
`default_nettype none

module tb;
    import ioxp_pkg::*;
    logic clk;
    logic rst;
    logic scl;
    logic sdaLow;
    logic sdaLine;
    logic sdaOut;
    logic sdaOe;
    logic [2:0] addrSel;
    logic [7:0] extPins;
    logic [7:0] portIn;
    ioxp_port_s portDrv;
    logic intOut;
    logic intOe;
    logic intLine;
    logic ack;
    logic [7:0] rd0;
    logic [7:0] rd1;
    int badCount;
    int checks;

    assign sdaLine = !(sdaLow || (sdaOe && !sdaOut));
    assign portIn = (portDrv.oe & portDrv.val) | (~portDrv.oe & extPins);
    assign intLine = !(intOe && !intOut);

    ioxp_expander uut (.clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrSel(addrSel), .portIn(portIn), .portDrv(portDrv), .intOut(intOut), .intOe(intOe));
    ioxp_host_model mst (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            badCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (badCount == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wrReg(input logic [1:0] cmd, input logic [7:0] d);
        mst.regWrite(addrSel, cmd, d, ack);
        check(ack, 1'b0);
    endtask

    task automatic rdReg(input logic setCmd, input logic [1:0] cmd, input logic [7:0] exp);
        logic [7:0] d;
        mst.regRead(addrSel, setCmd, cmd, d);
        check(d, exp);
    endtask

    task automatic waitInt(input logic exp);
        int n;
        n = 0;
        while (intLine !== !exp && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        check(intLine, !exp);
        if (intLine !== !exp)
            conclude();
    endtask

    initial
    begin
        rst = 1'b1;
        addrSel = 3'h2;
        extPins = 8'ha5;
        badCount = 0;
        checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check(portDrv, 16'hff00);
        check(intOe, 1'b0);
        rdReg(1'b1, 2'h1, 8'hff);
        rdReg(1'b1, 2'h2, 8'h00);
        rdReg(1'b1, 2'h3, 8'hff);
        rdReg(1'b1, 2'h0, 8'ha5);
        wrReg(2'h1, 8'h3c);
        wrReg(2'h3, 8'hf0);
        check(portDrv, 16'h3c0f);
        rdReg(1'b1, 2'h0, 8'hac);
        rdReg(1'b1, 2'h1, 8'h3c);
        wrReg(2'h2, 8'hff);
        check(portDrv, 16'h3c0f);
        rdReg(1'b1, 2'h0, 8'h53);
        rdReg(1'b0, 2'h0, 8'h53);
        wrReg(2'h3, 8'hff);
        wrReg(2'h2, 8'h00);
        wrReg(2'h0, 8'h00);
        rdReg(1'b1, 2'h0, 8'ha5);
        waitInt(1'b0);
        extPins <= 8'ha4;
        waitInt(1'b1);
        extPins <= 8'ha5;
        waitInt(1'b0);
        extPins <= 8'hb5;
        waitInt(1'b1);
        rdReg(1'b0, 2'h0, 8'hb5);
        mst.regRead2(addrSel, rd0, rd1);
        check(rd0, 8'hb5);
        check(rd1, 8'hb5);
        waitInt(1'b0);
        for (int a = 0; a < 8; a++)
        begin
            mst.xfer(a[2:0], 1'b0, ack);
            check(ack, a != 2);
            mst.stop();
        end
        addrSel <= 3'h5;
        @(posedge clk);
        rdReg(1'b1, 2'h2, 8'h00);
        wrReg(2'h2, 8'h0f);
        wrReg(2'h3, 8'h00);
        check(portDrv, 16'h3cff);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check(portDrv, 16'hff00);
        rdReg(1'b1, 2'h2, 8'h00);
        conclude();
    end
endmodule

`default_nettype wire
